// ==== rtl/opig_guard.sv ====
// Integrity guard on the OTP program read path with boot load and lock
// Summary of operation
// - Mode 00h: unchecked bytes, full 4kB space
// - Mode 0Fh: parity byte checks, corrects single-bit code errors
// - Mode F0h: four copies, space limited to 2kB
// - Mirrored fetch delivers AND of four banks
// - Unprogrammed bits read as one
// - Cleared lock-disable bits block external readout
// - Lock acts only after programming and power-on reset
// - Power-on reset auto-loads firmware and configuration
`timescale 1ns/10ps
module opig_guard
  import opig_pkg::*;
#(
  parameter int AW = OPIG_AW,
  parameter int BOOT_BYTES = OPIG_FULL_BYTES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Fetch and host read request
  input wire opig_req_type req_i,
  input wire logic sram_exec_i,
  // OTP array port, one-cycle read latency
  output logic [AW-1:0] otp_addr_o,
  output logic otp_rd_o,
  input wire logic [7:0] otp_code_i,
  input wire logic [7:0] otp_par_i,
  // Answer
  output opig_rsp_type rsp_o,
  // Boot copy to SRAM and configuration
  output logic boot_we_o,
  output logic [AW-1:0] boot_addr_o,
  output logic [7:0] boot_data_o,
  output logic boot_done_o,
  output logic [7:0] mode_o,
  output logic readout_lock_active_o
);
  typedef enum logic [2:0] {S_CFG1, S_CFG2, S_COPY, S_RUN} boot_st_type;

  boot_st_type st_q;
  logic [1:0] quad_q;
  logic [7:0] acc_q;
  logic [AW-1:0] ptr_q;
  logic [7:0] mode_q;
  logic lock_q;
  logic pend_q;
  logic pend_ext_q;
  logic pend_d_q;
  logic qrow0_q;
  logic copy_q;
  logic [AW-1:0] rd_addr_q;
  logic [7:0] fixed;
  logic flip_err;
  logic [7:0] syn;
  opig_mode_type mode_dec;

  // Parity code: bit i carries the XOR of code bits i, i+1 and i+3 (mod 8)
  function automatic logic [7:0] par_gen(input logic [7:0] d);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      p[i] = d[i] ^ d[(i + 1) % 8] ^ d[(i + 3) % 8];
    end
    return p;
  endfunction : par_gen

  always_comb begin
    unique case (mode_q)
      OPIG_MODE_DIRECT: mode_dec = OPIG_ST_DIRECT;
      OPIG_MODE_PARITY: mode_dec = OPIG_ST_PARITY;
      OPIG_MODE_QUAD: mode_dec = OPIG_ST_QUAD;
      default: mode_dec = OPIG_ST_RSVD;
    endcase
  end

  // Single-bit correction: syndrome matches the column of one code bit
  always_comb begin
    syn = par_gen(otp_code_i) ^ otp_par_i;
    fixed = otp_code_i;
    flip_err = 1'b0;
    for (int b = 0; b < 8; b++) begin
      if (syn == par_gen(8'h01 << b)) begin
        fixed[b] = ~otp_code_i[b];
        flip_err = 1'b1;
      end
    end
  end

  // Boot sequencer: read config bytes, then copy program to SRAM
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q <= S_CFG1;
      ptr_q <= '0;
    end else begin
      case (st_q)
        S_CFG1: st_q <= S_CFG2;
        S_CFG2: st_q <= S_COPY;
        S_COPY: begin
          if (ptr_q == AW'(BOOT_BYTES - 1)) begin
            st_q <= S_RUN;
          end
          ptr_q <= ptr_q + AW'(1);
        end
        S_RUN: st_q <= S_RUN;
        default: st_q <= S_CFG1;
      endcase
    end
  end

  // Mode and lock are latched only during boot, so writes take effect
  // after the next power-on reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mode_q <= OPIG_MODE_DIRECT;
      lock_q <= 1'b0;
    end else begin
      if (st_q == S_CFG2) begin
        mode_q <= otp_code_i;
      end
      // Byte on the port in the first copy cycle is the cfg2 read
      if (st_q == S_COPY && ptr_q == '0) begin
        lock_q <= (otp_code_i[OPIG_LOCK_LSB +: 2] == 2'h0);
      end
    end
  end

  // Array addressing. Read is held on cfg1 through reset so its byte is
  // on the port when boot starts. A mirrored fetch reads two rows: the
  // code plane carries banks 0 and 1, the parity plane banks 2 and 3
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      otp_addr_o <= OPIG_CFG1_ADDR;
      otp_rd_o <= 1'b1;
      quad_q <= 2'h0;
      pend_q <= 1'b0;
      pend_ext_q <= 1'b0;
    end else begin
      otp_rd_o <= 1'b1;
      pend_q <= 1'b0;
      case (st_q)
        S_CFG1: otp_addr_o <= OPIG_CFG2_ADDR;
        S_CFG2: otp_addr_o <= '0;
        S_COPY: otp_addr_o <= ptr_q + AW'(1);
        default: begin
          otp_rd_o <= 1'b0;
          quad_q <= 2'h0;
          if (quad_q == 2'h1) begin
            otp_rd_o <= 1'b1;
            otp_addr_o <= otp_addr_o | (AW'(1) << OPIG_BANK_SHIFT);
            pend_q <= 1'b1;
          end else if (req_i.valid) begin
            otp_rd_o <= 1'b1;
            pend_ext_q <= req_i.ext;
            if (mode_dec == OPIG_ST_QUAD) begin
              otp_addr_o <= AW'(req_i.addr[OPIG_BANK_SHIFT-1:0]);
              quad_q <= 2'h1;
            end else begin
              otp_addr_o <= req_i.addr[AW-1:0];
              pend_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Tags for the byte returning from the array, one cycle behind its read
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pend_d_q <= 1'b0;
      qrow0_q <= 1'b0;
      copy_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      pend_d_q <= pend_q;
      qrow0_q <= (quad_q == 2'h1);
      copy_q <= (st_q == S_COPY);
      rd_addr_q <= otp_addr_o;
    end
  end

  // First row of a mirrored fetch waits here for the second one;
  // reset value is the blank level of the array
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      acc_q <= OPIG_BLANK;
    end else if (qrow0_q) begin
      acc_q <= otp_code_i & otp_par_i;
    end
  end

  // Answer stage
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o <= '0;
      if (pend_d_q) begin
        rsp_o.valid <= 1'b1;
        if (pend_ext_q && lock_q) begin
          rsp_o.refused <= 1'b1;
          rsp_o.data <= OPIG_BLANK;
        end else if (mode_dec == OPIG_ST_QUAD) begin
          rsp_o.data <= acc_q & otp_code_i & otp_par_i;
        end else if (mode_dec == OPIG_ST_PARITY) begin
          rsp_o.data <= fixed;
          rsp_o.corrected <= flip_err;
        end else begin
          rsp_o.data <= otp_code_i;
        end
      end
    end
  end

  // Boot copy writes raw array bytes, corrected ones in parity mode; no mask is applied on this path
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      boot_we_o <= 1'b0;
      boot_addr_o <= '0;
      boot_data_o <= '0;
      boot_done_o <= 1'b0;
      mode_o <= OPIG_MODE_DIRECT;
      readout_lock_active_o <= 1'b0;
    end else begin
      boot_we_o <= copy_q;
      boot_addr_o <= rd_addr_q;
      boot_data_o <= (mode_dec == OPIG_ST_PARITY) ? fixed : otp_code_i;
      boot_done_o <= (st_q == S_RUN);
      mode_o <= mode_q;
      readout_lock_active_o <= lock_q && (st_q == S_RUN || sram_exec_i);
    end
  end

  property p_quad_two_reads;
    @(posedge clk_i) disable iff (!rst_b_i)
      (st_q == S_RUN && mode_dec == OPIG_ST_QUAD && req_i.valid &&
       quad_q == 2'h0) |=> otp_rd_o [*2];
  endproperty
  a_quad_two_reads: assert property (p_quad_two_reads)
    else $error("quad fetch did not read both rows of banks");

  property p_quad_bank_limit;
    @(posedge clk_i) disable iff (!rst_b_i)
      (st_q == S_RUN && mode_dec == OPIG_ST_QUAD && req_i.valid &&
       quad_q == 2'h0) |=> !otp_addr_o[OPIG_BANK_SHIFT]
        ##1 otp_addr_o[OPIG_BANK_SHIFT];
  endproperty
  a_quad_bank_limit: assert property (p_quad_bank_limit)
    else $error("quad fetch not in first 2kB bank");

  property p_lock_refuses;
    @(posedge clk_i) disable iff (!rst_b_i)
      (rsp_o.valid && $past(pend_ext_q) && $past(lock_q)) |-> rsp_o.refused;
  endproperty
  a_lock_refuses: assert property (p_lock_refuses)
    else $error("locked external read not refused");

  property p_lock_stable;
    @(posedge clk_i) disable iff (!rst_b_i)
      (st_q == S_RUN) |=> $stable(lock_q) && $stable(mode_q);
  endproperty
  a_lock_stable: assert property (p_lock_stable)
    else $error("lock or mode changed without power-on reset");

  property p_boot_starts;
    @(posedge clk_i) disable iff (!rst_b_i)
      $rose(rst_b_i) |-> ##4 boot_we_o;
  endproperty
  a_boot_starts: assert property (p_boot_starts)
    else $error("boot copy did not start after reset");

  property p_direct_pass;
    @(posedge clk_i) disable iff (!rst_b_i)
      (pend_d_q && !(pend_ext_q && lock_q) && mode_dec == OPIG_ST_DIRECT)
        |=> rsp_o.data == $past(otp_code_i);
  endproperty
  a_direct_pass: assert property (p_direct_pass)
    else $error("direct mode altered a byte");

  property p_parity_clean;
    @(posedge clk_i) disable iff (!rst_b_i)
      (pend_d_q && mode_dec == OPIG_ST_PARITY && syn == 8'h00 &&
       !(pend_ext_q && lock_q)) |=> rsp_o.data == $past(otp_code_i) &&
       !rsp_o.corrected;
  endproperty
  a_parity_clean: assert property (p_parity_clean)
    else $error("clean parity byte altered");

  property p_copy_raw;
    @(posedge clk_i) disable iff (!rst_b_i)
      (copy_q && mode_dec != OPIG_ST_PARITY)
        |=> boot_we_o && boot_data_o == $past(otp_code_i);
  endproperty
  a_copy_raw: assert property (p_copy_raw)
    else $error("boot copy changed a byte");
endmodule : opig_guard

// ==== rtl/opig_pkg.sv ====
// Package for the program memory integrity guard: modes, addresses, carriers
package opig_pkg;
  localparam int OPIG_AW = 12;
  localparam int OPIG_DW = 8;
  localparam int OPIG_FULL_BYTES = 4096;
  localparam int OPIG_QUAD_BYTES = 2048;
  localparam int OPIG_BANK_SHIFT = 11;
  localparam logic [7:0] OPIG_MODE_DIRECT = 8'h00;
  localparam logic [7:0] OPIG_MODE_PARITY = 8'h0F;
  localparam logic [7:0] OPIG_MODE_QUAD = 8'hF0;
  localparam logic [7:0] OPIG_BLANK = 8'hFF;
  localparam logic [11:0] OPIG_CFG1_ADDR = 12'h001;
  localparam logic [11:0] OPIG_CFG2_ADDR = 12'h002;
  localparam int OPIG_LOCK_LSB = 0;
  localparam logic [1:0] OPIG_LOCK_DIS_MASK = 2'h3;
  localparam logic [11:0] OPIG_CFG_BASE = 12'h000;
  localparam int OPIG_CFG_BYTES = 77;

  typedef enum logic [2:0] {
    OPIG_ST_DIRECT,
    OPIG_ST_PARITY,
    OPIG_ST_QUAD,
    OPIG_ST_RSVD
  } opig_mode_type;

  typedef struct packed {
    logic valid;
    logic ext;
    logic [11:0] addr;
  } opig_req_type;

  typedef struct packed {
    logic valid;
    logic refused;
    logic corrected;
    logic [7:0] data;
  } opig_rsp_type;
endpackage : opig_pkg

// ==== tb/opig_otp_model.sv ====
// Behavioural OTP array: code and parity planes, one-cycle read
`timescale 1ns/10ps
module opig_otp_model
  import opig_pkg::*;
#(
  parameter int AW = OPIG_AW
) (
  // Clock
  input wire logic clk_i,
  // Array port
  input wire logic [AW-1:0] addr_i,
  input wire logic rd_i,
  output logic [7:0] code_o,
  output logic [7:0] par_o
);
  logic [7:0] code_mem [2**AW];
  logic [7:0] par_mem [2**AW];

  initial begin
    code_o = OPIG_BLANK;
    par_o = OPIG_BLANK;
    foreach (code_mem[i]) begin
      code_mem[i] = OPIG_BLANK;
      par_mem[i] = OPIG_BLANK;
    end
  end

  // Outputs toggle between reads, so a stale byte returns after every even number of idle cycles
  always @(posedge clk_i) begin
    if (rd_i) begin
      code_o <= code_mem[addr_i];
      par_o <= par_mem[addr_i];
    end else begin
      code_o <= ~code_o;
      par_o <= ~par_o;
    end
  end
endmodule : opig_otp_model

// ==== tb/testbench.sv ====
// Self-checking bench for the program memory integrity guard
`timescale 1ns/10ps
module testbench
  import opig_pkg::*;
;
  localparam int NB = 16;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  opig_req_type req_i = '0;
  logic sram_exec_i = 1'b0;
  logic [11:0] otp_addr_o, boot_addr_o;
  logic otp_rd_o, boot_we_o, boot_done_o, readout_lock_active_o;
  logic [7:0] otp_code_i, otp_par_i, boot_data_o, mode_o;
  opig_rsp_type rsp_o;
  int err_total = 0;
  int checked = 0;
  int boot_n = 0;
  logic boot_chk = 1'b0;
  logic [15:0] seed = 16'h5333;

  opig_guard #(.AW(OPIG_AW), .BOOT_BYTES(NB)) i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
    .sram_exec_i(sram_exec_i), .otp_addr_o(otp_addr_o),
    .otp_rd_o(otp_rd_o), .otp_code_i(otp_code_i), .otp_par_i(otp_par_i),
    .rsp_o(rsp_o), .boot_we_o(boot_we_o), .boot_addr_o(boot_addr_o),
    .boot_data_o(boot_data_o), .boot_done_o(boot_done_o),
    .mode_o(mode_o), .readout_lock_active_o(readout_lock_active_o));
  opig_otp_model #(.AW(OPIG_AW)) i_otp (
    .clk_i(clk_i), .addr_i(otp_addr_o), .rd_i(otp_rd_o),
    .code_o(otp_code_i), .par_o(otp_par_i));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [7:0] par_of(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      par_of[i] = d[i] ^ d[(i + 1) % 8] ^ d[(i + 3) % 8];
    end
  endfunction : par_of

  // Mirrored byte: banks 0 and 1 in the code plane, 2 and 3 in parity
  function automatic logic [7:0] quad_exp(input logic [11:0] a);
    return i_otp.code_mem[a] & i_otp.code_mem[a + 12'h800] &
           i_otp.par_mem[a] & i_otp.par_mem[a + 12'h800];
  endfunction : quad_exp

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Power-on reset, then wait for the boot copy to finish
  task automatic do_reset();
    rst_b_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int n = 0; n < NB + 30; n++) begin
      @(posedge clk_i);
      if (boot_done_o === 1'b1) begin
        @(posedge clk_i);
        return;
      end
    end
    err_total++;
    stop_test();
  endtask : do_reset

  task automatic rd(input logic ext, input logic [11:0] a,
                    output opig_rsp_type r);
    req_i <= {1'b1, ext, a};
    @(posedge clk_i);
    req_i.valid <= 1'b0;
    for (int n = 0; n < 10; n++) begin
      @(posedge clk_i);
      if (rsp_o.valid === 1'b1) begin
        r = rsp_o;
        return;
      end
    end
    err_total++;
    stop_test();
  endtask : rd

  always @(posedge clk_i) begin
    if (rst_b_i === 1'b0) begin
      boot_n <= 0;
    end else if (boot_we_o === 1'b1) begin
      if (boot_chk) begin
        cmp(boot_data_o, i_otp.code_mem[boot_addr_o]);
        cmp(boot_addr_o[7:0], 8'(boot_n));
      end
      boot_n <= boot_n + 1;
    end
  end

  initial begin
    opig_rsp_type r;
    logic [11:0] a;
    logic [7:0] d;
    @(posedge clk_i);
    for (int i = 3; i < NB; i++) begin
      seed = lfsr(seed);
      i_otp.code_mem[i] = seed[7:0];
    end
    i_otp.code_mem[OPIG_CFG2_ADDR] = 8'h03;
    i_otp.code_mem[1] = OPIG_MODE_DIRECT;
    boot_chk = 1'b1;
    do_reset();
    boot_chk = 1'b0;
    cmp(8'(boot_n), 8'(NB));
    cmp(mode_o, OPIG_MODE_DIRECT);
    cmp(8'(readout_lock_active_o), 8'h00);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      a = seed[11:0];
      if (seed[12] && a > 12'h00F) i_otp.code_mem[a] = seed[15:8];
      rd(1'b1, a, r);
      cmp(r.data, i_otp.code_mem[a]);
    end
    $display("direct test done");
    // Lock written to the array acts only after the next reset
    i_otp.code_mem[OPIG_CFG2_ADDR] = 8'h00;
    rd(1'b1, 12'h005, r);
    cmp(8'(r.refused), 8'h00);
    do_reset();
    cmp(8'(readout_lock_active_o), 8'h01);
    rd(1'b1, 12'h005, r);
    cmp(8'(r.refused), 8'h01);
    cmp(r.data, OPIG_BLANK);
    rd(1'b0, 12'h005, r);
    cmp(r.data, i_otp.code_mem[5]);
    $display("lock test done");
    i_otp.code_mem[OPIG_CFG2_ADDR] = 8'h03;
    i_otp.code_mem[1] = OPIG_MODE_PARITY;
    for (int i = 0; i < NB; i++) begin
      i_otp.par_mem[i] = par_of(i_otp.code_mem[i]);
    end
    rd(1'b0, OPIG_CFG1_ADDR, r);
    do_reset();
    cmp(mode_o, OPIG_MODE_PARITY);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      a = 12'h100 + 12'(i);
      i_otp.code_mem[a] = d ^ (8'h01 << i);
      i_otp.par_mem[a] = par_of(d);
      rd(1'b1, a, r);
      cmp(r.data, d);
      cmp(8'(r.corrected), 8'h01);
    end
    $display("parity test done");
    i_otp.code_mem[1] = OPIG_MODE_QUAD;
    rd(1'b0, OPIG_CFG1_ADDR, r);
    do_reset();
    cmp(mode_o, OPIG_MODE_QUAD);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      a = {1'b0, seed[10:0]} | 12'h020;
      i_otp.code_mem[a] = seed[15:8];
      i_otp.code_mem[a + 12'h800] = seed[7:0] | 8'h81;
      seed = lfsr(seed);
      i_otp.par_mem[a] = seed[15:8] | 8'h18;
      i_otp.par_mem[a + 12'h800] = seed[7:0] | 8'h24;
      rd(1'b0, a, r);
      cmp(r.data, quad_exp(a));
    end
    $display("quad test done");
    // Reserved pattern: the guard falls back to unchecked pass-through
    i_otp.code_mem[1] = 8'h5A;
    rd(1'b0, OPIG_CFG1_ADDR, r);
    do_reset();
    cmp(mode_o, 8'h5A);
    rd(1'b1, 12'h123, r);
    cmp(r.data, i_otp.code_mem[12'h123]);
    $display("reserved mode test done");
    stop_test();
  end
endmodule : testbench
